// >>> shared/abcas_pkg.sv
// Constants for the second gain stage control and sync block.
// Assumes a 32-bit APB master; register indices map to byte address index*4.
`default_nettype none
package abcas_pkg;
	// ==========================================================
	// Register indices
	localparam logic [7:0] IDX_CTRL    = 8'h12;
	localparam logic [7:0] IDX_HOLD    = 8'h13;
	localparam logic [7:0] IDX_TARGET  = 8'h14;
	localparam logic [7:0] IDX_IGAIN   = 8'h15;
	localparam logic [7:0] IDX_LOOP    = 8'h16;
	localparam logic [7:0] IDX_POLE    = 8'h17;
	localparam logic [7:0] IDX_AVG     = 8'h18;
	localparam logic [7:0] IDX_RATIO   = 8'h19;
	localparam logic [7:0] IDX_ENABLE  = 8'h20;
	localparam logic [7:0] IDX_STATUS  = 8'h21;
	// ==========================================================
	// Control fields
	localparam int CTRL_WLEN_LSB = 5;
	localparam int CTRL_MODE     = 4;
	localparam int CTRL_SYNCNOW  = 3;
	localparam int CTRL_INIT     = 2;
	localparam int CTRL_IGNREP   = 1;
	localparam int CTRL_BYPASS   = 0;
	localparam int AVG_SCALE_LSB = 2;
	localparam int TGT_EXP_LSB   = 6;
	localparam int IG_EXP_LSB    = 8;
	// ==========================================================
	// Reset values
	localparam logic [7:0]  RST_CTRL   = 8'h00;
	localparam logic [15:0] RST_HOLD   = 16'h0000;
	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam logic [11:0] RST_12     = 12'h000;
	localparam logic [5:0]  RST_AVG    = 6'h00;
	localparam logic        RST_ENABLE = 1'b0;

	function automatic logic [7:0] byte_addr(input logic [7:0] idx);
		byte_addr = {idx[5:0], 2'b00};
	endfunction

	// Word length code to bit count
	function automatic logic [4:0] wlen_bits(input logic [2:0] code);
		case (code)
			3'h0: wlen_bits = 5'h04;
			3'h1: wlen_bits = 5'h05;
			3'h2: wlen_bits = 5'h06;
			3'h3: wlen_bits = 5'h07;
			3'h4: wlen_bits = 5'h08;
			3'h5: wlen_bits = 5'h0A;
			3'h6: wlen_bits = 5'h0C;
			default: wlen_bits = 5'h10;
		endcase
	endfunction
endpackage
`default_nettype wire

// >>> logic/abcas_top.sv
// Control, sync and parameter loading of the second gain stage.
// Assumes an APB master on i_mclk and a raw sync pin from outside.
//
// The APB slave port is this design's own decision.
`default_nettype none
// Functional notes
// - Control bits 7-5 pick output word length 4,5,6,7,8,10,12,16.
// - Mode bit 4: clear tracks level, set tracks clipping error.
// - Hold-off counter triggers from the channel 2 sync pin.
// - A sync pin rising edge retriggers the hold-off counter unless ignore-repeat blocks it.
// - Software or pin sync loads the 16-bit hold-off delay.
// - Hold-off value zero makes the stage unsynchronizable by pin.
// - Writing sync-now starts a new update at once; self clearing.
// - Init bit plus sync-now clears CIC and loads all loop parameters.
// - Every sync-now while enabled emits an update; without init nothing reloads.
// - Ignore-repeat set honours only the first pin sync until cleared.
// - Bypass passes the top 16 of 24 input bits unchanged.
// - Target level register holds level or clipping target.
// - Target level is 2-bit exponent plus 6-bit mantissa.
// - Initial gain is 4-bit exponent plus 8-bit mantissa, seeds multiplier.
// - Loop gain coefficient taken up only at initialization.
// - Pole coefficient taken up only at initialization.
// - Averaging bits 5-2 scale the CIC, bits 1-0 count 1 to 4 samples.
// - Update ratio code sets CIC decimation 1 to 4096.
// - Enable low shuts down interleave, filtering and gain loop.
module abcas_top
	import abcas_pkg::*;
#(
	parameter int HOLD_W  = 16,
	parameter int RATIO_W = 12
) (
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output var  logic [31:0] o_prdata,
	output var  logic        o_pready,
	output var  logic        o_pslverr,
	input  wire logic        i_sync_ch2,
	input  wire logic [23:0] i_hb_data,
	input  wire logic        i_hb_valid,
	output var  logic [15:0] o_out_data,
	output var  logic        o_out_valid,
	output var  logic        o_update,
	output var  logic [31:0] o_update_value,
	output var  logic        o_init,
	output var  logic        o_clip_mode,
	output var  logic [4:0]  o_word_len,
	output var  logic [1:0]  o_target_exp,
	output var  logic [5:0]  o_target_mant,
	output var  logic [3:0]  o_gain_exp,
	output var  logic [7:0]  o_gain_mant,
	output var  logic [7:0]  o_loop_coeff,
	output var  logic [7:0]  o_pole_coeff
);
	if (HOLD_W != 16 || RATIO_W != 12) begin : g_width_check
		$error("abcas_top: register widths are fixed by the map");
	end

	// ==========================================================
	// Registers
	logic [7:0]  ctrl_reg;
	logic [15:0] hold_reg;
	logic [7:0]  target_reg;
	logic [11:0] igain_reg;
	logic [7:0]  loop_reg;
	logic [7:0]  pole_reg;
	logic [5:0]  avg_reg;
	logic [11:0] ratio_reg;
	logic        enable_reg;
	logic        syncnow_reg;
	// Active copies, loaded only at initialization
	logic [11:0] act_ratio_reg;
	logic [5:0]  act_avg_reg;
	// Sync path
	logic        sync_s1_reg;
	logic        sync_s2_reg;
	logic        sync_d_reg;
	logic        seen_reg;
	logic        busy_reg;
	logic [15:0] hcnt_reg;
	// CIC path
	logic [31:0] acc_reg;
	logic [1:0]  avg_cnt_reg;
	logic [11:0] dec_cnt_reg;

	logic        wr_acc;
	logic        setup;
	logic        sync_rise;
	logic        pin_evt;
	logic        expire;
	logic        init_evt;
	logic        update_evt;
	logic        take;
	logic        group_end;
	logic        dec_end;
	logic [15:0] pwr;

	assign setup  = i_psel & ~i_penable;
	assign wr_acc = i_psel & i_penable & o_pready & i_pwrite;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
		hit = (a == byte_addr(idx));
	endfunction

	// ==========================================================
	// APB slave, zero wait states
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0000_0000;
		end else begin
			o_pready  <= setup;
			o_pslverr <= 1'b0;
			if (setup) begin
				o_prdata <= 32'h0000_0000;
				if (hit(i_paddr, IDX_CTRL))
					o_prdata[7:0] <= ctrl_reg;
				else if (hit(i_paddr, IDX_HOLD))
					o_prdata[15:0] <= hold_reg;
				else if (hit(i_paddr, IDX_TARGET))
					o_prdata[7:0] <= target_reg;
				else if (hit(i_paddr, IDX_IGAIN))
					o_prdata[11:0] <= igain_reg;
				else if (hit(i_paddr, IDX_LOOP))
					o_prdata[7:0] <= loop_reg;
				else if (hit(i_paddr, IDX_POLE))
					o_prdata[7:0] <= pole_reg;
				else if (hit(i_paddr, IDX_AVG))
					o_prdata[5:0] <= avg_reg;
				else if (hit(i_paddr, IDX_RATIO))
					o_prdata[11:0] <= ratio_reg;
				else if (hit(i_paddr, IDX_ENABLE))
					o_prdata[0] <= enable_reg;
				else if (hit(i_paddr, IDX_STATUS))
					o_prdata[17:0] <= {seen_reg, busy_reg, hcnt_reg};
				else
					o_pslverr <= 1'b1;
			end
		end
	end

	// Sync-now bit is never stored, so it always reads zero
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_reg   <= RST_CTRL;
			hold_reg   <= RST_HOLD;
			target_reg <= RST_BYTE;
			igain_reg  <= RST_12;
			loop_reg   <= RST_BYTE;
			pole_reg   <= RST_BYTE;
			avg_reg    <= RST_AVG;
			ratio_reg  <= RST_12;
			enable_reg <= RST_ENABLE;
		end else if (wr_acc) begin
			if (hit(i_paddr, IDX_CTRL)) begin
				ctrl_reg <= i_pwdata[7:0];
				ctrl_reg[CTRL_SYNCNOW] <= 1'b0;
			end
			if (hit(i_paddr, IDX_HOLD))
				hold_reg <= i_pwdata[15:0];
			if (hit(i_paddr, IDX_TARGET))
				target_reg <= i_pwdata[7:0];
			if (hit(i_paddr, IDX_IGAIN))
				igain_reg <= i_pwdata[11:0];
			if (hit(i_paddr, IDX_LOOP))
				loop_reg <= i_pwdata[7:0];
			if (hit(i_paddr, IDX_POLE))
				pole_reg <= i_pwdata[7:0];
			if (hit(i_paddr, IDX_AVG))
				avg_reg <= i_pwdata[5:0];
			if (hit(i_paddr, IDX_RATIO))
				ratio_reg <= i_pwdata[11:0];
			if (hit(i_paddr, IDX_ENABLE))
				enable_reg <= i_pwdata[0];
		end
	end

	// One-shot from each write of one
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n)
			syncnow_reg <= 1'b0;
		else
			syncnow_reg <= wr_acc & hit(i_paddr, IDX_CTRL) & i_pwdata[CTRL_SYNCNOW];
	end

	// ==========================================================
	// Pin sync and hold-off counter
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync_s1_reg <= 1'b0;
			sync_s2_reg <= 1'b0;
			sync_d_reg  <= 1'b0;
		end else begin
			sync_s1_reg <= i_sync_ch2;
			sync_s2_reg <= sync_s1_reg;
			sync_d_reg  <= sync_s2_reg;
		end
	end

	assign sync_rise = sync_s2_reg & ~sync_d_reg;
	assign pin_evt   = sync_rise & enable_reg & (hold_reg != 16'h0000)
		& ~(ctrl_reg[CTRL_IGNREP] & seen_reg);
	assign expire     = busy_reg & (hcnt_reg == 16'h0001);
	assign init_evt   = syncnow_reg & ctrl_reg[CTRL_INIT];
	assign update_evt = enable_reg & (syncnow_reg | expire);

	// Cleared only while the bit is low, so a set never races a clear
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n)
			seen_reg <= 1'b0;
		else if (!ctrl_reg[CTRL_IGNREP])
			seen_reg <= 1'b0;
		else if (pin_evt)
			seen_reg <= 1'b1;
	end

	// Sync-now bypasses the count; a new pin edge restarts it
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy_reg <= 1'b0;
			hcnt_reg <= 16'h0000;
		end else if (!enable_reg || syncnow_reg) begin
			busy_reg <= 1'b0;
			hcnt_reg <= syncnow_reg ? hold_reg : 16'h0000;
		end else if (pin_evt) begin
			busy_reg <= 1'b1;
			hcnt_reg <= hold_reg;
		end else if (busy_reg) begin
			busy_reg <= ~expire;
			hcnt_reg <= hcnt_reg - 16'h0001;
		end
	end

	// ==========================================================
	// Parameter load at initialization
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			act_ratio_reg <= RST_12;
			act_avg_reg   <= RST_AVG;
			o_gain_exp    <= 4'h0;
			o_gain_mant   <= 8'h00;
			o_loop_coeff  <= 8'h00;
			o_pole_coeff  <= 8'h00;
			o_init        <= 1'b0;
		end else begin
			o_init <= init_evt & enable_reg;
			if (init_evt && enable_reg) begin
				act_ratio_reg <= ratio_reg;
				act_avg_reg   <= avg_reg;
				o_gain_exp    <= igain_reg[11:IG_EXP_LSB];
				o_gain_mant   <= igain_reg[IG_EXP_LSB-1:0];
				o_loop_coeff  <= loop_reg;
				o_pole_coeff  <= pole_reg;
			end
		end
	end

	// Mode and level settings follow the registers directly
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_clip_mode   <= 1'b0;
			o_word_len    <= 5'h04;
			o_target_exp  <= 2'h0;
			o_target_mant <= 6'h00;
		end else begin
			o_clip_mode   <= ctrl_reg[CTRL_MODE];
			o_word_len    <= wlen_bits(ctrl_reg[7:CTRL_WLEN_LSB]);
			o_target_exp  <= target_reg[7:TGT_EXP_LSB];
			o_target_mant <= target_reg[TGT_EXP_LSB-1:0];
		end
	end

	// ==========================================================
	// Power averaging and CIC decimation
	assign take      = enable_reg & i_hb_valid & ~ctrl_reg[CTRL_BYPASS];
	assign pwr       = i_hb_data[23] ? (~i_hb_data[23:8] + 16'h0001) : i_hb_data[23:8];
	assign group_end = take & (avg_cnt_reg == act_avg_reg[1:0]);
	assign dec_end   = group_end & (dec_cnt_reg == act_ratio_reg);

	// Ratio code n decimates by n+1; hazard: scale must suit it
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			acc_reg        <= 32'h0000_0000;
			avg_cnt_reg    <= 2'h0;
			dec_cnt_reg    <= 12'h000;
			o_update       <= 1'b0;
			o_update_value <= 32'h0000_0000;
		end else begin
			o_update <= update_evt | (dec_end & ~init_evt);
			if (!enable_reg || init_evt) begin
				acc_reg     <= 32'h0000_0000;
				avg_cnt_reg <= 2'h0;
				dec_cnt_reg <= 12'h000;
			end else if (update_evt || dec_end) begin
				o_update_value <= (acc_reg + (take ? {16'h0000, pwr} : 32'h0000_0000))
					>> act_avg_reg[5:AVG_SCALE_LSB];
				acc_reg        <= 32'h0000_0000;
				avg_cnt_reg    <= 2'h0;
				dec_cnt_reg    <= 12'h000;
			end else if (take) begin
				acc_reg     <= acc_reg + {16'h0000, pwr};
				avg_cnt_reg <= group_end ? 2'h0 : avg_cnt_reg + 2'h1;
				if (group_end)
					dec_cnt_reg <= dec_cnt_reg + 12'h001;
			end
		end
	end

	// ==========================================================
	// Output word path; gain multiply sits downstream
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_out_data  <= 16'h0000;
			o_out_valid <= 1'b0;
		end else begin
			o_out_valid <= enable_reg & i_hb_valid;
			if (ctrl_reg[CTRL_BYPASS])
				o_out_data <= i_hb_data[23:8];
			else
				o_out_data <= i_hb_data[23:8]
					& ~(16'hFFFF >> wlen_bits(ctrl_reg[7:CTRL_WLEN_LSB]));
		end
	end

	// ==========================================================
	// Checks
	property p_bypass;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(enable_reg && i_hb_valid && ctrl_reg[CTRL_BYPASS]) |=> (o_out_data == $past(i_hb_data[23:8]));
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass word wrong");

	property p_load;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(pin_evt && !syncnow_reg) |=> (busy_reg && hcnt_reg == $past(hold_reg));
	endproperty
	a_load: assert property (p_load) else $error("hold-off not loaded");

	property p_zero;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(hold_reg == 16'h0000 && !busy_reg) |=> !busy_reg;
	endproperty
	a_zero: assert property (p_zero) else $error("sync with zero hold-off");

	property p_now;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(wr_acc && hit(i_paddr, IDX_CTRL) && i_pwdata[CTRL_SYNCNOW] && enable_reg)
			|=> ##1 o_update && !busy_reg;
	endproperty
	a_now: assert property (p_now) else $error("sync-now gave no update");

	property p_expire;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(busy_reg && hcnt_reg == 16'h0002 && enable_reg && !syncnow_reg && !pin_evt && !wr_acc)
			|=> ##1 o_update;
	endproperty
	a_expire: assert property (p_expire) else $error("expiry gave no update");

	property p_ign;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(ctrl_reg[CTRL_IGNREP] && seen_reg && !busy_reg) |=> !busy_reg;
	endproperty
	a_ign: assert property (p_ign) else $error("repeat sync honoured");

	property p_keep;
		@(posedge i_mclk) disable iff (!i_rst_n)
		!init_evt |=> $stable(o_loop_coeff) && $stable(o_pole_coeff);
	endproperty
	a_keep: assert property (p_keep) else $error("coeff changed without init");

	property p_init;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(init_evt && enable_reg) |=> o_pole_coeff == $past(pole_reg) && acc_reg == 32'h0000_0000;
	endproperty
	a_init: assert property (p_init) else $error("init did not load");

	property p_off;
		@(posedge i_mclk) disable iff (!i_rst_n)
		!enable_reg |=> !o_out_valid && !busy_reg;
	endproperty
	a_off: assert property (p_off) else $error("stage active while off");
endmodule // abcas_top
`default_nettype wire

// >>> tb/abcas_hb_model.sv
// Half-band source model feeding samples to the gain stage.
// Assumes the bench gates it with i_go while it reconfigures.
`default_nettype none
module abcas_hb_model (
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	input  wire logic        i_go,
	output var  logic [23:0] o_hb_data,
	output var  logic        o_hb_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Sample stream
	// Data scrambles every cycle, so a stale word never passes as fresh
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_hb_valid <= 1'b0;
			o_hb_data  <= 24'h000000;
		end else begin
			o_hb_valid <= i_go & ~o_hb_valid;
			o_hb_data  <= 24'($urandom());
		end
	end
endmodule // abcas_hb_model
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the gain stage control and sync block.
// Assumes APB with zero wait states and a raw sync pin.
`default_nettype none
module tb;
	import abcas_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, psel, pen, pwr, sync, go, hbv;
	logic [7:0] addr;
	logic [31:0] wd, prd, r, v;
	logic pready, perr, x, upd, ini, en, byp;
	logic [23:0] hbd;
	logic [15:0] od;
	logic ov, cm;
	logic [4:0] wlen;
	logic [1:0] te;
	logic [5:0] tm;
	logic [3:0] ge;
	logic [7:0] gm, lc, pc;
	logic [31:0] uv;
	int miscompares, samples_checked, cyc, upd_cnt, init_cnt, upd_cyc, t0, u, h, wl;
	logic [15:0] q[$];
	int acc_m, cnt_m, per_m, sc_m, a_m, n_m;
	bit cic_on;
	logic [31:0] uq[$];
	localparam logic [7:0] IDX[9] = '{IDX_CTRL, IDX_HOLD, IDX_TARGET, IDX_IGAIN, IDX_LOOP,
		IDX_POLE, IDX_AVG, IDX_RATIO, IDX_ENABLE};
	localparam logic [31:0] MSK[9] = '{32'hF3, 32'hFFFF, 32'hFF, 32'hFFF, 32'hFF, 32'hFF,
		32'h3F, 32'hFFF, 32'h1};
	localparam int WL[8] = '{4, 5, 6, 7, 8, 10, 12, 16};
	abcas_top abcas_top_inst (.i_mclk(clk), .i_rst_n(rst_n), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .o_prdata(prd),
		.o_pready(pready), .o_pslverr(perr), .i_sync_ch2(sync), .i_hb_data(hbd),
		.i_hb_valid(hbv), .o_out_data(od), .o_out_valid(ov), .o_update(upd),
		.o_update_value(uv), .o_init(ini), .o_clip_mode(cm), .o_word_len(wlen),
		.o_target_exp(te), .o_target_mant(tm), .o_gain_exp(ge), .o_gain_mant(gm),
		.o_loop_coeff(lc), .o_pole_coeff(pc));
	abcas_hb_model abcas_hb_model_inst (.i_mclk(clk), .i_rst_n(rst_n), .i_go(go),
		.o_hb_data(hbd), .o_hb_valid(hbv));
	// ==========================================================
	// Checks and bus tasks
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t %s got %0h exp %0h", $time, m, g, e);
		end
	endtask
	task automatic complete_run();
		$display("compares %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Request held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		addr <= {i[5:0], 2'b00};
		wd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prd;
		x = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		// Idle edge, so a second call never reassigns psel in this step
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		apb(1'b1, i, d);
		if (i == IDX_ENABLE) en = d[0];
		if (i == IDX_CTRL) byp = d[0];
	endtask
	task automatic rd(input logic [7:0] i, input logic [31:0] e, input logic er);
		apb(1'b0, i, 32'h0);
		chk(r, e, "read");
		chk(32'(x), 32'(er), "slverr");
	endtask
	task automatic pin_sync();
		sync <= 1'b1;
		t0 = cyc;
		u = upd_cnt;
		repeat (2) @(posedge clk);
		sync <= 1'b0;
	endtask
	task automatic wait_upd(input int n);
		for (int k = 0; k < n && upd_cnt == u; k++) @(posedge clk);
	endtask
	task automatic stream(input int n);
		go <= 1'b1;
		repeat (n) @(posedge clk);
		go <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	function automatic logic [15:0] exp_word(input logic [23:0] d);
		return byp ? d[23:8] : d[23:8] & (16'hFFFF << (16 - wl));
	endfunction
	// ==========================================================
	// Monitor, reference queue and timeout
	always @(posedge clk) begin
		cyc++;
		if (upd === 1'b1) begin
			upd_cnt++;
			upd_cyc = cyc;
		end
		if (ini === 1'b1) init_cnt++;
		if (upd === 1'b1 && cic_on) begin
			if (uq.size() == 0) chk(32'h1, 32'h0, "extra update");
			else chk(uv, uq.pop_front(), "update value");
		end
		if (hbv === 1'b1 && en === 1'b1 && byp === 1'b0 && cic_on) begin
			acc_m += hbd[23] ? 65536 - int'(hbd[23:8]) : int'(hbd[23:8]);
			cnt_m++;
			if (cnt_m == per_m) begin
				uq.push_back(32'(acc_m >> sc_m));
				acc_m = 0;
				cnt_m = 0;
			end
		end
		if (ov === 1'b1) begin
			if (q.size() == 0) chk(32'h1, 32'h0, "extra output");
			else chk(32'(od), 32'(q.pop_front()), "out word");
		end
		if (hbv === 1'b1 && en === 1'b1) q.push_back(exp_word(hbd));
		if (cyc == 20000) begin
			miscompares++;
			$display("[FAIL] %0t timeout", $time);
			complete_run();
		end
	end
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// ==========================================================
	// Main sequence
	initial begin
		{rst_n, psel, pen, pwr, sync, go, en, byp} = '0;
		addr = 8'h00;
		wd = 32'h0;
		void'($urandom(32'h0CA2));
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 9; i++) rd(IDX[i], 32'h0, 1'b0);
		chk(32'(wlen), 32'h4, "reset length");
		rd(8'h30, 32'h0, 1'b1);
		for (int i = 0; i < 9; i++) begin
			v = $urandom();
			wr(IDX[i], (i == 0) ? v & ~32'hC : v);
			rd(IDX[i], v & MSK[i], 1'b0);
		end
		$display("registers done");
		for (int c = 0; c < 8; c++) begin
			wr(IDX_CTRL, {c[2:0], c[0], 4'h0});
			repeat (2) @(posedge clk);
			chk(32'(wlen), WL[c], "length");
			chk(32'(cm), 32'(c[0]), "mode");
		end
		wr(IDX_TARGET, 32'hA5);
		repeat (2) @(posedge clk);
		chk(32'({te, tm}), 32'({2'h2, 6'h25}), "target");
		wr(IDX_IGAIN, 32'h789);
		wr(IDX_LOOP, 32'h5A);
		wr(IDX_POLE, 32'hC3);
		wr(IDX_ENABLE, 32'h1);
		u = upd_cnt;
		h = init_cnt;
		wr(IDX_CTRL, 32'h08);
		wr(IDX_CTRL, 32'h08);
		repeat (5) @(posedge clk);
		chk(upd_cnt - u, 2, "sync now");
		chk(init_cnt - h, 0, "no init");
		chk(32'({lc, pc, gm}), 32'h0, "params held");
		wr(IDX_CTRL, 32'h0C);
		repeat (5) @(posedge clk);
		chk(upd_cnt - u, 3, "init update");
		chk(init_cnt - h, 1, "init");
		chk(32'({ge, gm}), 32'h789, "gain");
		chk(32'({lc, pc}), 32'h5AC3, "coeffs");
		$display("sync now done");
		h = $urandom_range(10, 40);
		wr(IDX_ENABLE, 32'h1);
		wr(IDX_HOLD, 32'(h));
		wr(IDX_CTRL, 32'h0);
		pin_sync();
		wait_upd(200);
		chk(32'(upd_cyc - t0 inside {[h + 3 : h + 6]}), 32'h1, "holdoff");
		pin_sync();
		repeat (6) @(posedge clk);
		pin_sync();
		wait_upd(200);
		chk(32'(upd_cyc - t0 inside {[h + 3 : h + 6]}), 32'h1, "retrigger");
		wr(IDX_CTRL, 32'h2);
		pin_sync();
		wait_upd(200);
		pin_sync();
		wait_upd(h + 20);
		chk(upd_cnt - u, 0, "repeat ignored");
		wr(IDX_CTRL, 32'h0);
		pin_sync();
		wait_upd(200);
		chk(upd_cnt - u, 1, "repeat honoured");
		wr(IDX_HOLD, 32'h0);
		pin_sync();
		wait_upd(100);
		chk(upd_cnt - u, 0, "zero holdoff");
		$display("pin sync done");
		wr(IDX_CTRL, 32'h1);
		stream(40);
		v = $urandom_range(0, 7);
		wl = WL[v];
		wr(IDX_CTRL, {v[2:0], 5'h0});
		stream(40);
		a_m = $urandom_range(0, 3);
		n_m = $urandom_range(0, 5);
		// Scale grows with the period so no significant bits drop
		sc_m = (a_m + n_m) / 2;
		per_m = (a_m + 1) * (n_m + 1);
		wr(IDX_AVG, 32'(sc_m * 4 + a_m));
		wr(IDX_RATIO, 32'(n_m));
		wr(IDX_CTRL, 32'({v[2:0], 5'h0}) | 32'hC);
		repeat (3) @(posedge clk);
		acc_m = 0;
		cnt_m = 0;
		cic_on = 1'b1;
		stream(120);
		cic_on = 1'b0;
		chk(32'(uq.size()), 32'h0, "cic drained");
		$display("cic done");
		wr(IDX_ENABLE, 32'h0);
		stream(20);
		chk(32'(q.size()), 32'h0, "drained");
		$display("stream done");
		complete_run();
	end
endmodule // tb
`default_nettype wire
